// ---- verilog/mapper_cfg.svh ----
// mapper_cfg.svh: offsets, field positions, reset values and block shifts of the mapper
// assumes: included by the mapper package users; 32-bit apb data, word-aligned registers
`ifndef MAPPER_CFG_SVH
`define MAPPER_CFG_SVH

`define OFS_CTRL       8'h00
`define OFS_DEFAULT    8'h04
`define OFS_START      8'h08
`define OFS_END        8'h0c
`define OFS_ENTRY_CFG  8'h10
`define OFS_CMD        8'h14
`define OFS_STATUS     8'h18
`define OFS_BLOCKS     8'h1c

`define CTRL_BRK_ROM   0
`define CTRL_SIG_LO    8
`define CFG_TYPE_LO    0
`define CFG_SINGLE     3
`define CFG_OVERLAY    4
`define CFG_REF_LO     8
`define CMD_OP_LO      0
`define CMD_IDX_LO     8
`define ST_OVL_ERR     0
`define ST_EMPTY_ERR   1
`define ST_ALLOC_ERR   2
`define ST_DEF_ERR     3
`define ST_CONFIGURED  4

`define SIG_BITS_WIDE   5'd24
`define SIG_BITS_NARROW 5'd20
`define BLK_SHIFT_WIDE   12
`define BLK_SHIFT_NARROW 8
`define BOUND_W        20

`endif

// ---- verilog/mapper_pkg.sv ----
// mapper_pkg: descriptor and command types of the emulation memory mapper
// assumes: used through scoped names only
package mapper_pkg;
    typedef enum logic [2:0] {
        DESC_TGT_ROM = 3'h0,
        DESC_TGT_RAM = 3'h1,
        DESC_EMU_ROM = 3'h2,
        DESC_EMU_RAM = 3'h3,
        DESC_GUARDED = 3'h4
    } desc_t;

    typedef enum logic [2:0] {
        OP_NONE    = 3'h0,
        OP_ADD     = 3'h1,
        OP_DEL     = 3'h2,
        OP_DEL_ALL = 3'h3,
        OP_END     = 3'h4
    } op_t;
endpackage

// ---- verilog/emulation_memory_mapper.sv ----
// emulation_memory_mapper: range table that gives each processor address a descriptor
// assumes: apb master on pclk; processor bus signals already synchronous to pclk
`timescale 1ns/1ps
`include "mapper_cfg.svh"

module emulation_memory_mapper #(
    parameter int          ENTRIES      = 32,
    parameter bit          WIDE_CPU     = 1'b1,
    parameter int          ADDR_W       = 24,
    parameter logic [15:0] TOTAL_BLOCKS = 16'h0010
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // processor address side
    input  wire logic [ADDR_W-1:0] cpu_addr,
    input  wire logic              cpu_valid,
    input  wire logic              cpu_write,
    // descriptor to memory resources and break logic
    output logic      [2:0]        desc,
    output logic      [15:0]       emul_blk,
    output logic                   emul_sel,
    output logic                   emul_wr,
    output logic                   brk
);
    localparam int SHIFT = WIDE_CPU ? `BLK_SHIFT_WIDE : `BLK_SHIFT_NARROW;

    // aligns a bound down to its block
    function automatic logic [19:0] blk_floor(input logic [19:0] a);
        blk_floor = (a >> SHIFT) << SHIFT;
    endfunction

    // block index of an offset within a range; callers pass a masked offset
    function automatic logic [15:0] blk_num(input logic [23:0] a);
        blk_num = 16'(a >> SHIFT);
    endfunction

    // true for the two descriptors that own emulation blocks
    function automatic logic is_emul(input logic [2:0] d);
        is_emul = (d == mapper_pkg::DESC_EMU_ROM) || (d == mapper_pkg::DESC_EMU_RAM);
    endfunction

    // registers
    logic        brk_rom_ff;
    logic [4:0]  sig_bits_ff;
    logic [2:0]  dflt_ff;
    logic [19:0] start_ff;
    logic [19:0] end_ff;
    logic [12:0] cfg_ff;
    // status and block accounting
    logic [3:0]  err_ff;
    logic        configured_ff;
    logic [15:0] avail_ff;
    logic [15:0] next_blk_ff;
    // apb answer
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    // table, stored as flip-flops indexed by entry number
    logic        ent_vld_ff  [ENTRIES];
    logic        ent_own_ff  [ENTRIES];
    logic [2:0]  ent_desc_ff [ENTRIES];
    logic [19:0] ent_lo_ff   [ENTRIES];
    logic [19:0] ent_hi_ff   [ENTRIES];
    logic [15:0] ent_base_ff [ENTRIES];
    logic [15:0] ent_cnt_ff  [ENTRIES];

    // outputs
    logic [2:0]  desc_ff;
    logic [15:0] emul_blk_ff;
    logic        emul_sel_ff;
    logic        emul_wr_ff;
    logic        brk_ff;

    // apb decode: one wait state; a write lands at the edge pready is seen, read data is latched one edge earlier
    wire         setup_acc = psel & penable & ~pready_ff;
    wire         done      = psel & penable & pready_ff;
    wire         wr_done   = done & pwrite;
    wire         mapped    = (paddr[1:0] == 2'b00) && (paddr <= `OFS_BLOCKS);
    wire         wr_ctrl   = wr_done & (paddr == `OFS_CTRL);
    wire         wr_dflt   = wr_done & (paddr == `OFS_DEFAULT);
    wire         wr_start  = wr_done & (paddr == `OFS_START);
    wire         wr_end    = wr_done & (paddr == `OFS_END);
    wire         wr_cfg    = wr_done & (paddr == `OFS_ENTRY_CFG);
    wire         wr_cmd    = wr_done & (paddr == `OFS_CMD);
    wire         wr_stat   = wr_done & (paddr == `OFS_STATUS);


    // command decode: a command acts at its own pready edge only
    wire [2:0]   cmd_op    = pwdata[`CMD_OP_LO +: 3];
    wire [4:0]   cmd_idx   = pwdata[`CMD_IDX_LO +: 5];
    wire         do_add    = wr_cmd & (cmd_op == mapper_pkg::OP_ADD);
    wire         do_del    = wr_cmd & (cmd_op == mapper_pkg::OP_DEL);
    wire         do_delall = wr_cmd & (cmd_op == mapper_pkg::OP_DEL_ALL);
    wire         do_end    = wr_cmd & (cmd_op == mapper_pkg::OP_END);

    // new entry geometry
    wire [2:0]   new_desc  = cfg_ff[`CFG_TYPE_LO +: 3];
    wire         new_ovl   = cfg_ff[`CFG_OVERLAY];
    wire [4:0]   ref_idx   = cfg_ff[`CFG_REF_LO +: 5];
    wire [19:0]  new_lo    = blk_floor(start_ff);
    wire [19:0]  raw_hi    = cfg_ff[`CFG_SINGLE] ? start_ff : end_ff;
    wire [19:0]  new_hi    = blk_floor(raw_hi) | 20'((21'h0_0001 << SHIFT) - 21'h1);
    wire [15:0]  new_cnt   = 16'((new_hi - new_lo) >> SHIFT) + 16'h0001;
    wire         new_emul  = is_emul(new_desc);
    wire         bad_type  = new_desc > mapper_pkg::DESC_GUARDED;
    // an end below the start is refused rather than swapped
    wire         bad_range = raw_hi < start_ff;
    wire         ref_ok    = ent_vld_ff[ref_idx] & is_emul(ent_desc_ff[ref_idx]);
    wire         ovl_err   = do_add & new_emul & new_ovl & ~ref_ok;
    wire         need_blks = new_emul & ~new_ovl;
    wire [16:0]  blk_top   = {1'b0, next_blk_ff} + {1'b0, new_cnt};
    wire         no_room   = need_blks & ((new_cnt > avail_ff) | (blk_top > {1'b0, TOTAL_BLOCKS}));
    wire         add_err   = do_add & (ent_vld_ff[cmd_idx] | bad_type | bad_range | no_room);
    wire         add_ok    = do_add & ~add_err & ~ovl_err;
    wire [15:0]  new_base  = new_ovl ? ent_base_ff[ref_idx] : next_blk_ff;

    // only entries that took blocks give them back on delete
    wire         del_own   = do_del & ent_vld_ff[cmd_idx] & ent_own_ff[cmd_idx];
    wire         dflt_err  = wr_dflt & (is_emul(pwdata[2:0]) | (pwdata[2:0] > 3'h4));

    logic        any_vld;
    always_comb begin
        any_vld = 1'b0;
        for (int i = 0; i < ENTRIES; i++) begin
            any_vld = any_vld | ent_vld_ff[i];
        end
    end
    wire         empty_err = do_end & ~any_vld;

    // address lookup: significant bits only, lowest entry wins
    wire [23:0]  sig_mask = 24'((25'h000_0001 << sig_bits_ff) - 25'h1);
    wire [23:0]  cpu_m    = 24'(cpu_addr) & sig_mask;
    // one comparator pair per entry; the loop runs downward so that
    // the lowest index is the last to write hit_idx
    logic        hit;
    logic [4:0]  hit_idx;
    always_comb begin
        hit     = 1'b0;
        hit_idx = 5'h00;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (ent_vld_ff[i] && (cpu_m >= {4'h0, ent_lo_ff[i] & sig_mask[19:0]})
                && (cpu_m <= {4'h0, ent_hi_ff[i] & sig_mask[19:0]})) begin
                hit     = 1'b1;
                hit_idx = 5'(i);
            end
        end
    end
    wire [2:0]   cur_desc = hit ? ent_desc_ff[hit_idx] : dflt_ff;
    // offset counts from the floored low bound, so overlay aliases line up
    wire [15:0]  cur_blk  = ent_base_ff[hit_idx] + blk_num(cpu_m - {4'h0, ent_lo_ff[hit_idx]});
    wire         cur_emul = hit & is_emul(cur_desc);
    wire         cur_rom  = (cur_desc == mapper_pkg::DESC_EMU_ROM)
                          | (cur_desc == mapper_pkg::DESC_TGT_ROM);
    wire         cur_grd  = cur_desc == mapper_pkg::DESC_GUARDED;

    // read mux; cmd reads as zero, unmapped offsets return zero with pslverr
    logic [31:0] rd_val;
    always_comb begin
        case (paddr)
            `OFS_CTRL:      rd_val = {19'h0, sig_bits_ff, 7'h0, brk_rom_ff};
            `OFS_DEFAULT:   rd_val = {29'h0, dflt_ff};
            `OFS_START:     rd_val = {12'h0, start_ff};
            `OFS_END:       rd_val = {12'h0, end_ff};
            `OFS_ENTRY_CFG: rd_val = {19'h0, cfg_ff};
            `OFS_STATUS:    rd_val = {27'h0, configured_ff, err_ff};
            `OFS_BLOCKS:    rd_val = {TOTAL_BLOCKS - avail_ff, avail_ff};
            default:        rd_val = 32'h0000_0000;
        endcase
    end

    // apb handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup_acc;
            pslverr_ff <= setup_acc & ~mapped;
            // read data latched in the wait state, held until the next access; a write loads zero
            if (setup_acc) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
            end
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_rom_ff  <= 1'b0;
            sig_bits_ff <= WIDE_CPU ? `SIG_BITS_WIDE : `SIG_BITS_NARROW;
            dflt_ff     <= mapper_pkg::DESC_TGT_RAM;
            start_ff    <= 20'h0_0000;
            end_ff      <= 20'h0_0000;
            cfg_ff      <= 13'h0000;
        end else begin
            if (wr_ctrl) begin
                brk_rom_ff  <= pwdata[`CTRL_BRK_ROM];
                sig_bits_ff <= (pwdata[`CTRL_SIG_LO +: 5] > 5'd24) ? 5'd24
                                                                  : pwdata[`CTRL_SIG_LO +: 5];
            end
            if (wr_dflt && !dflt_err) begin
                dflt_ff <= pwdata[2:0];
            end
            if (wr_start) begin
                start_ff <= pwdata[`BOUND_W-1:0];
            end
            if (wr_end) begin
                end_ff <= pwdata[`BOUND_W-1:0];
            end
            if (wr_cfg) begin
                cfg_ff <= pwdata[12:0];
            end
        end
    end

    // status: a new error wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ff        <= 4'h0;
            configured_ff <= 1'b0;
        end else begin
            err_ff <= (err_ff & ~({4{wr_stat}} & pwdata[3:0]))
                    | {dflt_err, add_err, empty_err, ovl_err};
            // configured drops only when the whole map is cleared
            if (do_end && any_vld) begin
                configured_ff <= 1'b1;
            end else if (do_delall) begin
                configured_ff <= 1'b0;
            end
        end
    end

    // block accounting; freed blocks are counted back but the bump pointer only
    // rewinds on delete-all, trading packing for a cheap allocator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            avail_ff    <= TOTAL_BLOCKS;
            next_blk_ff <= 16'h0000;
        end else if (do_delall) begin
            avail_ff    <= TOTAL_BLOCKS;
            next_blk_ff <= 16'h0000;
        end else if (add_ok && need_blks) begin
            avail_ff    <= avail_ff - new_cnt;
            next_blk_ff <= blk_top[15:0];
        end else if (del_own) begin
            avail_ff    <= avail_ff + ent_cnt_ff[cmd_idx];
        end
    end

    // entry table; a single delete keeps the stored bounds, only valid drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ENTRIES; i++) begin
                ent_vld_ff[i]  <= 1'b0;
                ent_own_ff[i]  <= 1'b0;
                ent_desc_ff[i] <= 3'h0;
                ent_lo_ff[i]   <= 20'h0_0000;
                ent_hi_ff[i]   <= 20'h0_0000;
                ent_base_ff[i] <= 16'h0000;
                ent_cnt_ff[i]  <= 16'h0000;
            end
        end else if (do_delall) begin
            for (int i = 0; i < ENTRIES; i++) begin
                ent_vld_ff[i] <= 1'b0;
            end
        end else if (do_del) begin
            ent_vld_ff[cmd_idx] <= 1'b0;
        end else if (add_ok) begin
            ent_vld_ff[cmd_idx]  <= 1'b1;
            ent_desc_ff[cmd_idx] <= new_desc;
            ent_own_ff[cmd_idx]  <= need_blks;
            ent_lo_ff[cmd_idx]   <= new_lo;
            ent_hi_ff[cmd_idx]   <= new_hi;
            ent_base_ff[cmd_idx] <= new_emul ? new_base : 16'h0000;
            ent_cnt_ff[cmd_idx]  <= need_blks ? new_cnt : 16'h0000;
        end
    end

    // per-access answer, one cycle after the address
    // registering costs a cycle but keeps the descriptor free of glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desc_ff     <= 3'h0;
            emul_blk_ff <= 16'h0000;
            emul_sel_ff <= 1'b0;
            emul_wr_ff  <= 1'b0;
            brk_ff      <= 1'b0;
        end else begin
            desc_ff     <= cur_desc;
            emul_blk_ff <= cur_emul ? cur_blk : 16'h0000;
            emul_sel_ff <= cpu_valid & cur_emul;
            emul_wr_ff  <= cpu_valid & cpu_write & cur_emul & ~cur_rom;
            brk_ff      <= cpu_valid & (cur_grd
                         | (cpu_write & cur_rom & brk_rom_ff));
        end
    end


    // every output straight from a flip-flop
    assign prdata   = prdata_ff;
    assign pready   = pready_ff;
    assign pslverr  = pslverr_ff;
    assign desc     = desc_ff;
    assign emul_blk = emul_blk_ff;
    assign emul_sel = emul_sel_ff;
    assign emul_wr  = emul_wr_ff;
    assign brk      = brk_ff;
endmodule // emulation_memory_mapper

// ---- test/emulation_memory_mapper_properties.sv ----
// checker: apb handshake and lookup relations of the mapper
// assumes: bound to emulation_memory_mapper, one clock domain
`timescale 1ns/1ps
module mapper_checker #(parameter int ADDR_W = 24) (
    // clock, reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // processor side
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic              cpu_valid,
    input wire logic              cpu_write,
    input wire logic [2:0]        desc,
    input wire logic [15:0]       emul_blk,
    input wire logic              emul_sel,
    input wire logic              emul_wr,
    input wire logic              brk
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    sequence s_answer; !pready ##1 pready; endsequence
    property p_wait; s_setup ##1 s_access |-> s_answer; endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_unmap; s_access and pready && paddr > 8'h1c |-> pslverr; endproperty
    property p_emu; emul_sel |-> desc == 3'h2 || desc == 3'h3; endproperty
    property p_tgt; desc <= 3'h1 |-> !emul_sel && emul_blk == 16'h0000; endproperty
    property p_rom; emul_wr |-> desc == 3'h3 && $past(cpu_write); endproperty
    property p_ram; desc == 3'h3 && $past(cpu_valid) |-> emul_sel && emul_wr == $past(cpu_write);
    endproperty
    property p_guard; desc == 3'h4 && $past(cpu_valid) |-> brk; endproperty
    property p_brk; brk |-> $past(cpu_valid) && (desc == 3'h4 || $past(cpu_write)); endproperty
    a_wait: assert property (p_wait) else $error("pready not after one wait");
    a_err: assert property (p_err) else $error("pslverr without pready");
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    a_emu: assert property (p_emu) else $error("emul_sel outside emulation");
    a_tgt: assert property (p_tgt) else $error("target uses a block");
    a_rom: assert property (p_rom) else $error("write reached rom");
    a_ram: assert property (p_ram) else $error("ram access restricted");
    a_guard: assert property (p_guard) else $error("guarded without break");
    a_brk: assert property (p_brk) else $error("break without cause");
endmodule // mapper_checker

bind emulation_memory_mapper mapper_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_addr, .cpu_valid,
    .cpu_write, .desc, .emul_blk, .emul_sel, .emul_wr, .brk);

// ---- test/cpu_bus_model.sv ----
// cpu_bus_model: processor address side facing the mapper
// assumes: bench requests change right after pclk edges
`timescale 1ns/1ps
module cpu_bus_model (
    // clock, reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // bench request
    input  wire logic [23:0] req_addr,
    input  wire logic        req_wr,
    input  wire logic        req_go,
    // processor bus
    output logic      [23:0] cpu_addr,
    output logic             cpu_valid,
    output logic             cpu_write
);
    // idle address and write lines toggle, valid stays low: a stale address would hide a late sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_addr  <= 24'h00_0000;
            cpu_valid <= 1'b0;
            cpu_write <= 1'b0;
        end else begin
            cpu_addr  <= req_go ? req_addr : ~cpu_addr;
            cpu_valid <= req_go;
            cpu_write <= req_go ? req_wr : ~cpu_write;
        end
    end
endmodule // cpu_bus_model

// ---- test/emulation_memory_mapper_tb.sv ----
// emulation_memory_mapper_tb: table set over apb, lookups through cpu_bus_model
// assumes: mapper_pkg, checker and cpu_bus_model compiled first
`timescale 1ns/1ps
`include "mapper_cfg.svh"
module emulation_memory_mapper_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, brk_rom;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] req_addr, cpu_addr, a;
    logic        req_wr, req_go, cpu_valid, cpu_write, emul_sel, emul_wr, brk;
    logic [2:0]  desc, dflt;
    logic [15:0] emul_blk;
    logic [19:0] lo [32], hi [32];
    logic [2:0]  dsc [32];
    logic [15:0] base [32];
    bit          vld [32];
    int          num_errors, checks, avail, nxt, n;
    logic [23:0] probe [9] = '{24'h00_1010, 24'h00_8010, 24'h00_3004, 24'h00_5fff,
        24'h00_6000, 24'h00_7000, 24'h00_2000, 24'h10_1004, 24'h00_9000};

    emulation_memory_mapper dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cpu_addr, .cpu_valid, .cpu_write, .desc, .emul_blk,
        .emul_sel, .emul_wr, .brk);
    cpu_bus_model cpu (.pclk, .presetn, .req_addr, .req_wr, .req_go, .cpu_addr, .cpu_valid,
        .cpu_write);
    always #50 pclk = ~pclk;

    task automatic chk_reg(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t reg %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_look(logic [21:0] got, logic [21:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t lookup %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(bit w, logic [7:0] ad, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic add(int i, logic [19:0] s, logic [19:0] e, logic [31:0] cfg);
        logic [4:0] r;
        int nb;
        r = cfg[12:8];
        apb(1'b1, `OFS_START, {12'h000, s});
        apb(1'b1, `OFS_END, {12'h000, e});
        apb(1'b1, `OFS_ENTRY_CFG, cfg);
        apb(1'b1, `OFS_CMD, (32'(i) << 8) | 32'h0000_0001);
        if (cfg[4] && !(vld[r] && dsc[r][2:1] == 2'b01)) return;
        vld[i] = 1'b1;
        dsc[i] = cfg[2:0];
        lo[i] = s & 20'hf_f000;
        hi[i] = (cfg[3] ? s : e) | 20'h0_0fff;
        nb = (int'(hi[i]) - int'(lo[i]) + 1) >> 12;
        base[i] = cfg[4] ? base[r] : 16'(nxt);
        if (!cfg[4] && cfg[2:1] == 2'b01) begin
            nxt += nb;
            avail -= nb;
        end
    endtask
    function automatic logic [21:0] expect_look(logic [23:0] ad, bit w);
        logic [2:0]  d;
        logic [15:0] b;
        logic        emu;
        d = dflt;
        b = 16'h0000;
        // walk downward so the lowest matching entry is the one kept
        for (int j = 31; j >= 0; j--) begin
            if (vld[j] && ad[19:0] >= lo[j] && ad[19:0] <= hi[j]) begin
                d = dsc[j];
                b = base[j] + 16'((ad[19:0] - lo[j]) >> 12);
            end
        end
        emu = d[2:1] == 2'b01;
        return {d, emu ? b : 16'h0000, emu, w && d == 3'h3, d == 3'h4 || (brk_rom && w && !d[0] && !d[2])};
    endfunction
    task automatic look(logic [23:0] ad, bit w);
        req_addr <= ad;
        req_wr <= w;
        req_go <= 1'b1;
        @(posedge pclk);
        req_go <= 1'b0;
        @(posedge pclk);
        #1;
        chk_look({desc, emul_blk, emul_sel, emul_wr, brk}, expect_look(ad, w));
        @(posedge pclk);
    endtask
    task automatic blocks;
        apb(1'b0, `OFS_BLOCKS, 32'h0000_0000);
        chk_reg(rd, {16'(16 - avail), 16'(avail)});
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        num_errors++;
        results();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, req_addr, req_wr, req_go} = '0;
        {brk_rom, nxt, avail, dflt} = {1'b0, 32'd0, 32'd16, 3'h1};
        void'($urandom(32'hd8c6_203e));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `OFS_CTRL, 32'h0000_0000);
        chk_reg(rd, 32'h0000_1800);
        apb(1'b0, `OFS_DEFAULT, 32'h0000_0000);
        chk_reg(rd, 32'h0000_0001);
        blocks();
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk_reg({31'h0, er}, 32'h0000_0001);
        apb(1'b1, `OFS_CMD, 32'h0000_0004);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk_reg(rd & 32'h0000_0012, 32'h0000_0002);
        $display("test reset done");
        add(0, 20'h0_1010, 20'h0_1fff, 32'h0000_0002);
        add(1, 20'h0_8020, 20'h0_0000, 32'h0000_001b);
        add(2, 20'h0_3000, 20'h0_3fff, 32'h0000_0004);
        add(3, 20'h0_5010, 20'h0_6001, 32'h0000_0003);
        add(4, 20'h0_2000, 20'h0_2fff, 32'h0000_0000);
        add(5, 20'h0_1000, 20'h0_1fff, 32'h0000_0001);
        blocks();
        apb(1'b1, `OFS_STATUS, 32'h0000_000f);
        add(6, 20'h0_a000, 20'h0_afff, 32'h0000_0413);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk_reg(rd & 32'h0000_0001, 32'h0000_0001);
        apb(1'b1, `OFS_CTRL, 32'h0000_1401);
        brk_rom = 1'b1;
        for (int k = 0; k < 18; k++) look(probe[k / 2], k[0]);
        repeat (150) look({$urandom_range(15, 0), 20'($urandom_range(32'hafff, 0))}, $urandom);
        $display("test lookup done");
        apb(1'b1, `OFS_DEFAULT, 32'h0000_0002);
        apb(1'b0, `OFS_DEFAULT, 32'h0000_0000);
        chk_reg(rd, 32'h0000_0001);
        apb(1'b1, `OFS_DEFAULT, 32'h0000_0004);
        dflt = 3'h4;
        look(24'h00_9000, 1'b0);
        apb(1'b1, `OFS_CMD, 32'h0000_0004);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk_reg(rd & 32'h0000_0018, 32'h0000_0018);
        apb(1'b1, `OFS_CMD, 32'h0000_0302);
        vld[3] = 1'b0;
        avail += 2;
        blocks();
        look(24'h00_5000, 1'b1);
        apb(1'b1, `OFS_CMD, 32'h0000_0003);
        vld = '{default: 1'b0};
        avail = 16;
        blocks();
        look(24'h00_1000, 1'b0);
        $display("test delete done");
        results();
    end
endmodule // emulation_memory_mapper_tb
